// ==== rtl/pdc_cfg_slave.sv ====
// Configuration bus slave: strobe, write enable, acknowledge
module pdc_cfg_slave
  import pdc_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  input  wire logic              bus_clk_i,
  input  wire logic              bus_reset_i,
  input  wire pdc_bus_req_t      req_i,
  input  wire logic [DATA_W-1:0] rd_val_i,
  output logic                   wr_o,
  output logic [DATA_W-1:0]      rdata_o,
  output logic                   ack_o
);

  logic              bclk_prev_r;
  logic              bedge;
  logic              ack_r;
  logic              ack_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic              take;

  // Bus clock sampled; it must run below half the core rate
  assign bedge = bus_clk_i && !bclk_prev_r;
  assign take  = bedge && req_i.stb && !ack_r && !bus_reset_i;
  assign wr_o  = take && req_i.we;

  always_comb begin
    ack_nxt   = ack_r;
    rdata_nxt = rdata_r;
    if (bedge) begin
      ack_nxt = take;
      if (take) begin
        rdata_nxt = rd_val_i;
      end
    end
    // bus reset clears only the interface
    if (bus_reset_i) begin
      ack_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      bclk_prev_r <= 1'b0;
      ack_r       <= 1'b0;
      rdata_r     <= '0;
    end else begin
      bclk_prev_r <= bus_clk_i;
      ack_r       <= ack_nxt;
      rdata_r     <= rdata_nxt;
    end
  end

  assign ack_o   = ack_r;
  assign rdata_o = rdata_r;

  chk_ack_after_take: assert property (@(posedge clk_i) disable iff (reset_i)
    take |=> ack_o ##1 (ack_o throughout !bus_clk_i || bclk_prev_r))
    else $error("access not acknowledged");
  chk_bus_reset_ack: assert property (@(posedge clk_i) disable iff (reset_i)
    bus_reset_i |=> !ack_o)
    else $error("ack survived bus reset");

endmodule : pdc_cfg_slave

// ==== rtl/pdc_loop_ctrl.sv ====
// Loop control top: dividers, phase stepping, lock, config bus
// What this block does
// - Output phase set from stored value or stepped at run time.
// - Reference clock switches between two sources under user control.
// - Configuration bus rewrites divider settings while running.
// - Each step toggle in ports mode shifts the selected output by exactly one step.
// - Lock output high while loop locked; receiver synchronises it.
// - Output shows whether phase control comes from ports or bus.
// - Standby powers loop down; outputs invalid until released and relocked.
// - Loop reset resets loop but keeps feedback divider.
// - Full loop reset also resets feedback divider.
// - Third divider reset clears only the third output divider.
// - Fourth divider reset clears only the fourth output divider.
// - Each output has its own enable gating its toggling.
// - One primary and three secondary phase-adjustable output clocks.
// - Bus reset clears bus interface only, keeps stored settings.
// - Bus transfers clocked by separate bus clock input.
// - 8-bit write data in, separate 8-bit read data out.
// - Strobe and write enable qualify access; device acknowledges each.
module pdc_loop_ctrl
  import pdc_pkg::*;
#(
  parameter int             LOCK_CNT = LOCK_CYCLES,
  parameter logic [3:0]     EN_USED  = 4'hf
) (
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  input  wire logic              ref_clk_in_i,
  input  wire logic              alt_ref_clk_in_i,
  input  wire logic              ref_source_select_i,
  input  wire logic              feedback_clk_in_i,
  input  wire logic [1:0]        phase_out_select_i,
  input  wire logic              phase_step_direction_i,
  input  wire logic              phase_step_toggle_i,
  input  wire logic              loop_powerdown_i,
  input  wire logic              loop_reset_i,
  input  wire logic              full_loop_reset_i,
  input  wire logic              third_div_reset_i,
  input  wire logic              fourth_div_reset_i,
  input  wire logic              primary_out_en_i,
  input  wire logic              secondary_out_en_i,
  input  wire logic              third_out_en_i,
  input  wire logic              fourth_out_en_i,
  input  wire logic              cfg_bus_clk_i,
  input  wire logic              cfg_bus_reset_i,
  input  wire logic              cfg_bus_strobe_i,
  input  wire logic              cfg_bus_write_en_i,
  input  wire logic [ADDR_W-1:0] cfg_bus_addr_i,
  input  wire logic [DATA_W-1:0] cfg_bus_wdata_i,
  output logic [DATA_W-1:0]      cfg_bus_rdata_o,
  output logic                   cfg_bus_ack_o,
  output logic                   primary_out_clk_o,
  output logic                   secondary_out_clk_o,
  output logic                   third_out_clk_o,
  output logic                   fourth_out_clk_o,
  output logic                   lock_o,
  output logic                   phase_ctrl_source_o
);

  localparam int CNT_W = $clog2(LOCK_CNT + 1);

  pdc_bus_req_t      bus_req;
  pdc_phase_cmd_t    cmd;
  logic              bus_wr;
  logic [DATA_W-1:0] rd_val;

  logic [DATA_W-1:0] div_r [NUM_OUTS];
  logic [DATA_W-1:0] div_nxt [NUM_OUTS];
  logic [DATA_W-1:0] mdiv_r;
  logic [DATA_W-1:0] mdiv_nxt;
  logic [DATA_W-1:0] phase_r;
  logic [DATA_W-1:0] phase_nxt;
  logic [DATA_W-1:0] ctrl_r;
  logic [DATA_W-1:0] ctrl_nxt;
  logic              bus_step_r;
  logic              bus_step_nxt;

  logic              ref_prev_r;
  logic              fb_prev_r;
  logic              tog_prev_r;
  logic [DATA_W-1:0] mcnt_r;
  logic [DATA_W-1:0] mcnt_nxt;
  pdc_lock_state_t   lk_state_r;
  pdc_lock_state_t   lk_state_nxt;
  logic [CNT_W-1:0]  lk_cnt_r;
  logic [CNT_W-1:0]  lk_cnt_nxt;
  logic              lock_r;

  logic              ref_sel;
  logic              tick;
  logic              fb_edge;
  logic              loop_hold;
  logic              fb_stepped;
  logic              set_write;
  logic [NUM_OUTS-1:0] out_clk;
  logic [NUM_OUTS-1:0] out_en;
  logic [NUM_OUTS-1:0] out_rst;

  assign bus_req = '{stb: cfg_bus_strobe_i, we: cfg_bus_write_en_i,
                     addr: cfg_bus_addr_i, wdata: cfg_bus_wdata_i};

  // bus slave on the core clock, sampling the bus clock
  pdc_cfg_slave u_slave (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .bus_clk_i   (cfg_bus_clk_i),
    .bus_reset_i (cfg_bus_reset_i),
    .req_i       (bus_req),
    .rd_val_i    (rd_val),
    .wr_o        (bus_wr),
    .rdata_o     (cfg_bus_rdata_o),
    .ack_o       (cfg_bus_ack_o)
  );

  assign ref_sel   = ref_source_select_i ? alt_ref_clk_in_i : ref_clk_in_i;
  assign tick      = ref_sel && !ref_prev_r;
  assign fb_edge   = feedback_clk_in_i && !fb_prev_r;
  // standby holds loop like a reset
  assign loop_hold = loop_reset_i || full_loop_reset_i || loop_powerdown_i;

  assign phase_ctrl_source_o = phase_r[PH_SRC_BIT];

  always_comb begin
    if (phase_r[PH_SRC_BIT]) begin
      cmd.step = bus_step_r;
      cmd.dir  = phase_r[PH_DIR_BIT];
      cmd.sel  = phase_r[PH_SEL_LSB +: 2];
    end else begin
      cmd.step = phase_step_toggle_i && !tog_prev_r;
      cmd.dir  = phase_step_direction_i;
      cmd.sel  = phase_out_select_i;
    end
  end

  assign fb_stepped = cmd.step && (cmd.sel == ctrl_r[CT_FB_LSB +: 2]);
  assign set_write  = bus_wr && (bus_req.addr <= ADDR_DIV3);

  always_comb begin
    mdiv_nxt     = mdiv_r;
    phase_nxt    = phase_r;
    ctrl_nxt     = ctrl_r;
    bus_step_nxt = 1'b0;
    for (int i = 0; i < NUM_OUTS; i++) begin
      div_nxt[i] = div_r[i];
    end
    if (bus_wr) begin
      case (bus_req.addr)
        ADDR_MDIV:  mdiv_nxt   = bus_req.wdata;
        ADDR_DIV0:  div_nxt[0] = bus_req.wdata;
        ADDR_DIV1:  div_nxt[1] = bus_req.wdata;
        ADDR_DIV2:  div_nxt[2] = bus_req.wdata;
        ADDR_DIV3:  div_nxt[3] = bus_req.wdata;
        ADDR_PHASE: begin
          // Step bit is a trigger, never stored
          phase_nxt = bus_req.wdata & ~(8'h01 << PH_STEP_BIT);
          bus_step_nxt = bus_req.wdata[PH_STEP_BIT];
        end
        ADDR_CTRL:  ctrl_nxt   = bus_req.wdata;
        default:    mdiv_nxt   = mdiv_r;
      endcase
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    case (bus_req.addr)
      ADDR_MDIV:   rd_val = mdiv_r;
      ADDR_DIV0:   rd_val = div_r[0];
      ADDR_DIV1:   rd_val = div_r[1];
      ADDR_DIV2:   rd_val = div_r[2];
      ADDR_DIV3:   rd_val = div_r[3];
      ADDR_PHASE:  rd_val = phase_r;
      ADDR_CTRL:   rd_val = ctrl_r;
      ADDR_STATUS: rd_val = {5'h00, ref_source_select_i,
                             phase_r[PH_SRC_BIT], lock_r};
      ADDR_MCNT:   rd_val = mcnt_r;
      default:     rd_val = 8'h00;
    endcase
  end

  // Feedback divider and lock sequencing
  always_comb begin
    mcnt_nxt     = mcnt_r;
    lk_state_nxt = lk_state_r;
    lk_cnt_nxt   = lk_cnt_r;
    if (tick && !loop_hold) begin
      mcnt_nxt = (({1'b0, mcnt_r} + 9'h001) >= {1'b0, mdiv_r}) ? 8'h00
                 : DATA_W'(mcnt_r + 1'b1);
    end
    if (full_loop_reset_i) begin
      mcnt_nxt = 8'h00;
    end
    case (lk_state_r)
      LK_HELD: begin
        if (!loop_hold) begin
          lk_state_nxt = LK_WAIT_FB;
        end
      end
      LK_WAIT_FB: begin
        if (fb_edge) begin
          lk_state_nxt = LK_COUNT;
          lk_cnt_nxt   = '0;
        end
      end
      LK_COUNT: begin
        if (lk_cnt_r >= CNT_W'(LOCK_CNT - 1)) begin
          lk_state_nxt = LK_LOCKED;
        end else begin
          lk_cnt_nxt = CNT_W'(lk_cnt_r + 1'b1);
        end
      end
      LK_LOCKED: lk_state_nxt = LK_LOCKED;
      default:   lk_state_nxt = LK_HELD;
    endcase
    if (fb_stepped || set_write) begin
      lk_state_nxt = LK_WAIT_FB;
    end
    if (loop_hold) begin
      lk_state_nxt = LK_HELD;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mdiv_r     <= MDIV_RST;
      div_r[0]   <= DIV0_RST;
      div_r[1]   <= DIV1_RST;
      div_r[2]   <= DIV2_RST;
      div_r[3]   <= DIV3_RST;
      phase_r    <= PHASE_RST;
      ctrl_r     <= CTRL_RST;
      bus_step_r <= 1'b0;
      ref_prev_r <= 1'b0;
      fb_prev_r  <= 1'b0;
      tog_prev_r <= 1'b0;
      mcnt_r     <= 8'h00;
      lk_state_r <= LK_HELD;
      lk_cnt_r   <= '0;
      lock_r     <= 1'b0;
    end else begin
      mdiv_r     <= mdiv_nxt;
      div_r      <= div_nxt;
      phase_r    <= phase_nxt;
      ctrl_r     <= ctrl_nxt;
      bus_step_r <= bus_step_nxt;
      ref_prev_r <= ref_sel;
      fb_prev_r  <= feedback_clk_in_i;
      tog_prev_r <= phase_step_toggle_i;
      mcnt_r     <= mcnt_nxt;
      lk_state_r <= lk_state_nxt;
      lk_cnt_r   <= lk_cnt_nxt;
      lock_r     <= (lk_state_nxt == LK_LOCKED);
    end
  end

  assign lock_o = lock_r;

  assign out_en  = {fourth_out_en_i, third_out_en_i,
                    secondary_out_en_i, primary_out_en_i};
  assign out_rst = {fourth_div_reset_i || loop_hold,
                    third_div_reset_i || loop_hold,
                    {2{loop_hold}}};

  for (genvar g = 0; g < NUM_OUTS; g++) begin : g_out
    pdc_out_div #(
      .W       (DATA_W),
      .EN_USED (EN_USED[g])
    ) u_div (
      .clk_i       (clk_i),
      .reset_i     (reset_i),
      .div_reset_i (out_rst[g]),
      .tick_i      (tick),
      .div_i       (div_r[g]),
      .en_i        (out_en[g]),
      .step_i      (cmd.step && (cmd.sel == 2'(g))),
      .dir_i       (cmd.dir),
      .clk_o       (out_clk[g])
    );
  end

  assign primary_out_clk_o   = out_clk[0];
  assign secondary_out_clk_o = out_clk[1];
  assign third_out_clk_o     = out_clk[2];
  assign fourth_out_clk_o    = out_clk[3];

  chk_lock_hold_drop: assert property (@(posedge clk_i) disable iff (reset_i)
    loop_hold |=> !lock_o)
    else $error("lock high during reset or standby");
  chk_lock_count: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(lock_o) |-> $past(lk_state_r) == LK_COUNT
                   && $past(lk_cnt_r) == CNT_W'(LOCK_CNT - 1))
    else $error("lock rose early");
  chk_write_relock: assert property (@(posedge clk_i) disable iff (reset_i)
    set_write |=> !lock_o ##1 !lock_o)
    else $error("lock kept after setting rewrite");
  chk_fb_step_relock: assert property (@(posedge clk_i) disable iff (reset_i)
    fb_stepped |=> !lock_o)
    else $error("lock kept after feedback step");
  chk_m_kept: assert property (@(posedge clk_i) disable iff (reset_i)
    (loop_reset_i && !full_loop_reset_i) |=> $stable(mcnt_r))
    else $error("feedback divider moved on loop reset");
  chk_bus_reset_keep: assert property (@(posedge clk_i) disable iff (reset_i)
    cfg_bus_reset_i |=> $stable(mdiv_r) && $stable(phase_r))
    else $error("settings changed under bus reset");

endmodule : pdc_loop_ctrl

// ==== rtl/pdc_out_div.sv ====
// One output divider with phase step, enable and local reset
module pdc_out_div
  import pdc_pkg::*;
#(
  parameter int           W       = DIV_W,
  parameter bit           EN_USED = 1'b1
) (
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire logic         div_reset_i,
  input  wire logic         tick_i,
  input  wire logic [W-1:0] div_i,
  input  wire logic         en_i,
  input  wire logic         step_i,
  input  wire logic         dir_i,
  output logic              clk_o
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic [W-1:0] base;
  logic         clk_r;
  logic         clk_nxt;
  logic         last;

  // Divide by zero behaves as divide by one
  assign last = ({1'b0, cnt_r} + {{W{1'b0}}, 1'b1}) >= {1'b0, div_i};

  always_comb begin
    base    = cnt_r;
    cnt_nxt = cnt_r;
    clk_nxt = clk_r;
    if (tick_i) begin
      base = last ? '0 : W'(cnt_r + 1'b1);
    end
    cnt_nxt = base;
    if (step_i) begin
      if (dir_i) begin
        cnt_nxt = (({1'b0, base} + 2) > {1'b0, div_i}) ? '0 : W'(base + 1'b1);
      end else begin
        cnt_nxt = (base == '0) ? W'(div_i - 1'b1) : W'(base - 1'b1);
      end
    end
    clk_nxt = (cnt_nxt < (div_i >> 1)) && (en_i || !EN_USED);
    if (div_reset_i) begin
      cnt_nxt = '0;
      clk_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cnt_r <= '0;
      clk_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      clk_r <= clk_nxt;
    end
  end

  assign clk_o = clk_r;

  chk_en_gates_out: assert property (@(posedge clk_i) disable iff (reset_i)
    (EN_USED && !en_i) |=> !clk_o)
    else $error("output toggled while disabled");
  chk_div_reset_clear: assert property (@(posedge clk_i) disable iff (reset_i)
    div_reset_i |=> (cnt_r == '0) && !clk_o)
    else $error("divider not cleared by its reset");

endmodule : pdc_out_div

// ==== rtl/pdc_pkg.sv ====
// Shared constants and types for the loop control block
package pdc_pkg;

  localparam int          CLK_HZ        = 25_000_000;
  localparam int          LOCK_TIME_US  = 50;
  localparam int          LOCK_CYCLES   = LOCK_TIME_US * (CLK_HZ / 1_000_000);

  localparam int          NUM_OUTS      = 4;
  localparam int          DIV_W         = 8;
  localparam int          ADDR_W        = 5;
  localparam int          DATA_W        = 8;

  // Configuration bus register map
  localparam logic [4:0]  ADDR_MDIV     = 5'h00;
  localparam logic [4:0]  ADDR_DIV0     = 5'h01;
  localparam logic [4:0]  ADDR_DIV1     = 5'h02;
  localparam logic [4:0]  ADDR_DIV2     = 5'h03;
  localparam logic [4:0]  ADDR_DIV3     = 5'h04;
  localparam logic [4:0]  ADDR_PHASE    = 5'h05;
  localparam logic [4:0]  ADDR_CTRL     = 5'h06;
  localparam logic [4:0]  ADDR_STATUS   = 5'h07;
  localparam logic [4:0]  ADDR_MCNT     = 5'h08;

  // Reset values
  localparam logic [7:0]  MDIV_RST      = 8'h04;
  localparam logic [7:0]  DIV0_RST      = 8'h04;
  localparam logic [7:0]  DIV1_RST      = 8'h08;
  localparam logic [7:0]  DIV2_RST      = 8'h10;
  localparam logic [7:0]  DIV3_RST      = 8'h20;
  localparam logic [7:0]  PHASE_RST     = 8'h00;
  localparam logic [7:0]  CTRL_RST      = 8'h00;

  // Phase register fields
  localparam int          PH_SRC_BIT    = 0;
  localparam int          PH_SEL_LSB    = 1;
  localparam int          PH_DIR_BIT    = 3;
  localparam int          PH_STEP_BIT   = 4;
  // Control register fields
  localparam int          CT_FB_LSB     = 0;
  // Status register fields
  localparam int          ST_LOCK_BIT   = 0;
  localparam int          ST_SRC_BIT    = 1;
  localparam int          ST_REF_BIT    = 2;

  typedef struct packed {
    logic                 stb;
    logic                 we;
    logic [ADDR_W-1:0]    addr;
    logic [DATA_W-1:0]    wdata;
  } pdc_bus_req_t;

  typedef struct packed {
    logic                 step;
    logic                 dir;
    logic [1:0]           sel;
  } pdc_phase_cmd_t;

  typedef enum logic [1:0] {
    LK_HELD,
    LK_WAIT_FB,
    LK_COUNT,
    LK_LOCKED
  } pdc_lock_state_t;

endpackage : pdc_pkg

// ==== tb/pdc_bus_master.sv ====
// Bus master model for the configuration bus of the loop block
module pdc_bus_master
  import pdc_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              ack_i,
  input  wire logic [DATA_W-1:0] rdata_i,
  output logic                   bus_clk_o,
  output pdc_bus_req_t           req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    bus_clk_o = 1'b0;
    req_o     = '0;
  end
  task automatic access(input logic w, input logic [4:0] a,
                        input logic [7:0] d, output logic [7:0] q,
                        output bit ok);
    ok = 1'b0;
    q  = 8'h00;
    @(posedge clk_i) req_o <= '{1'b1, w, a, d};
    @(posedge clk_i) bus_clk_o <= 1'b1;
    for (int n = 0; n < 8 && !ok; n++) begin
      @(posedge clk_i);
      if (ack_i === 1'b1) begin
        ok = 1'b1;
        q  = rdata_i;
      end
    end
    // Released lines show the inverse, never the last value
    req_o     <= '{1'b0, ~w, ~a, ~d};
    bus_clk_o <= 1'b0;
    // One more bus edge clears ack, then the clock stops low
    @(posedge clk_i) bus_clk_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    bus_clk_o <= 1'b0;
  endtask : access
endmodule : pdc_bus_master

// ==== tb/pdc_loop_ctrl_tb.sv ====
// Self-checking bench for the loop control block
module pdc_loop_ctrl_tb
  import pdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LCNT = 8;
  logic         clk_i      = 1'b0;
  logic         reset_i    = 1'b1;
  logic         run        = 1'b0;
  logic [1:0]   tk         = 2'h0;
  logic         rsel       = 1'b0;
  logic [1:0]   psel       = 2'h0;
  logic         pdir       = 1'b0;
  logic         ptog       = 1'b0;
  logic         pdn        = 1'b0;
  logic         brst       = 1'b0;
  logic [3:0]   rs         = 4'h0;
  logic [3:0]   en         = 4'hf;
  logic         bclk;
  pdc_bus_req_t req;
  logic [7:0]   rdata;
  logic         ack;
  logic [3:0]   oclk;
  logic         lock;
  logic         src;
  int           failures   = 0;
  int           n_compared = 0;
  // Reference A every 2 cycles, B every 4; clocks stop when run is low
  wire          ref_a      = run & tk[0];
  wire          ref_b      = run & tk[1];
  wire          fb         = run & tk[1];

  initial begin
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) tk <= tk + 2'h1;

  pdc_bus_master bm (.clk_i(clk_i), .ack_i(ack), .rdata_i(rdata),
    .bus_clk_o(bclk), .req_o(req));

  pdc_loop_ctrl #(.LOCK_CNT(LCNT)) uut (.clk_i(clk_i), .reset_i(reset_i),
    .ref_clk_in_i(ref_a), .alt_ref_clk_in_i(ref_b),
    .ref_source_select_i(rsel), .feedback_clk_in_i(fb),
    .phase_out_select_i(psel), .phase_step_direction_i(pdir),
    .phase_step_toggle_i(ptog), .loop_powerdown_i(pdn),
    .loop_reset_i(rs[0]), .full_loop_reset_i(rs[1]),
    .third_div_reset_i(rs[2]), .fourth_div_reset_i(rs[3]),
    .primary_out_en_i(en[0]), .secondary_out_en_i(en[1]),
    .third_out_en_i(en[2]), .fourth_out_en_i(en[3]),
    .cfg_bus_clk_i(bclk), .cfg_bus_reset_i(brst),
    .cfg_bus_strobe_i(req.stb), .cfg_bus_write_en_i(req.we),
    .cfg_bus_addr_i(req.addr), .cfg_bus_wdata_i(req.wdata),
    .cfg_bus_rdata_o(rdata), .cfg_bus_ack_o(ack),
    .primary_out_clk_o(oclk[0]), .secondary_out_clk_o(oclk[1]),
    .third_out_clk_o(oclk[2]), .fourth_out_clk_o(oclk[3]),
    .lock_o(lock), .phase_ctrl_source_o(src));

  task automatic check(input string w, input logic [7:0] s,
                       input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", w, e, s);
    end
  endtask : check

  task automatic acc(input logic w, input logic [4:0] a,
                     input logic [7:0] d, input logic [7:0] e);
    logic [7:0] q;
    bit         ok;
    bm.access(w, a, d, q, ok);
    check("ack", {7'h00, ok}, 8'h01);
    if (!w) check($sformatf("reg %h", a), q, e);
  endtask : acc

  task automatic wait_lock(output int n);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (lock !== 1'b1 && n < 300);
  endtask : wait_lock

  task automatic t_regs();
    logic [7:0] rv [7];
    rv = '{MDIV_RST, DIV0_RST, DIV1_RST, DIV2_RST, DIV3_RST, PHASE_RST,
           CTRL_RST};
    for (int i = 0; i < 7; i++) acc(1'b0, 5'(i), 8'h00, rv[i]);
    for (int i = 0; i < 5; i++) begin
      acc(1'b1, 5'(i), 8'h31 + 8'(i), 8'h00);
      acc(1'b0, 5'(i), 8'h00, 8'h31 + 8'(i));
    end
    @(posedge clk_i) brst <= 1'b1;
    repeat (3) @(posedge clk_i);
    brst <= 1'b0;
    acc(1'b0, ADDR_DIV2, 8'h00, 8'h34);
    acc(1'b1, 5'h1f, 8'h5a, 8'h00);
    acc(1'b0, 5'h1f, 8'h00, 8'h00);
    for (int i = 0; i < 5; i++) acc(1'b1, 5'(i), rv[i], 8'h00);
    $display("test regs done");
  endtask : t_regs

  task automatic t_lock();
    int         n;
    run <= 1'b1;
    wait_lock(n);
    check("lock up", {7'h00, lock}, 8'h01);
    @(posedge clk_i) rs <= 4'h1;
    repeat (2) @(posedge clk_i);
    check("lock hold", {7'h00, lock}, 8'h00);
    rs <= 4'h0;
    wait_lock(n);
    check("relock", 8'(n >= LCNT && n <= LCNT + 8), 8'h01);
    acc(1'b1, ADDR_DIV0, DIV0_RST, 8'h00);
    check("lock drop", {7'h00, lock}, 8'h00);
    wait_lock(n);
    @(posedge clk_i) pdn <= 1'b1;
    repeat (3) @(posedge clk_i);
    check("standby", {3'h0, oclk, lock}, 8'h00);
    pdn <= 1'b0;
    wait_lock(n);
    check("standby relock", {7'h00, lock}, 8'h01);
    // Counts only hold still with the clocks stopped
    @(posedge clk_i) run <= 1'b0;
    repeat (4) @(posedge clk_i);
    rs <= 4'h2;
    @(posedge clk_i) rs <= 4'h0;
    acc(1'b0, ADDR_MCNT, 8'h00, 8'h00);
    // One reference cycle (two core cycles) gives exactly one count
    @(posedge clk_i) run <= 1'b1;
    repeat (2) @(posedge clk_i);
    run <= 1'b0;
    @(posedge clk_i) rs <= 4'h1;
    @(posedge clk_i) rs <= 4'h0;
    acc(1'b0, ADDR_MCNT, 8'h00, 8'h01);
    @(posedge clk_i) rs <= 4'h2;
    @(posedge clk_i) rs <= 4'h0;
    acc(1'b0, ADDR_MCNT, 8'h00, 8'h00);
    run <= 1'b1;
    $display("test lock done");
  endtask : t_lock

  task automatic watch(input logic [3:0] e);
    logic [3:0] p;
    logic [3:0] s;
    s = 4'h0;
    repeat (4) @(posedge clk_i);
    p = oclk;
    repeat (160) begin
      @(posedge clk_i);
      s |= oclk ^ p;
      p = oclk;
    end
    check("toggling", {4'h0, s}, {4'h0, e});
  endtask : watch

  task automatic t_out();
    watch(4'hf);
    @(posedge clk_i) en <= 4'b1010;
    watch(4'b1010);
    check("gated low", {4'h0, oclk & ~en}, 8'h00);
    @(posedge clk_i) en <= 4'hf;
    @(posedge clk_i) rs <= 4'h4;
    watch(4'b1011);
    @(posedge clk_i) rs <= 4'h8;
    watch(4'b0111);
    @(posedge clk_i) rs <= 4'h0;
    $display("test outputs done");
  endtask : t_out

  task automatic diff(input bit e);
    bit d;
    d = 1'b0;
    repeat (3) @(posedge clk_i);
    repeat (40) begin
      @(posedge clk_i);
      d |= oclk[0] !== oclk[1];
    end
    check("phase differs", {7'h00, d}, {7'h00, e});
  endtask : diff

  task automatic step(input logic [1:0] s, input logic dr);
    @(posedge clk_i) begin
      psel <= s;
      pdir <= dr;
    end
    @(posedge clk_i) ptog <= 1'b1;
    @(posedge clk_i) ptog <= 1'b0;
  endtask : step

  task automatic t_phase();
    int n;
    acc(1'b1, ADDR_DIV1, DIV0_RST, 8'h00);
    acc(1'b1, ADDR_CTRL, 8'h01, 8'h00);
    acc(1'b0, ADDR_CTRL, 8'h00, 8'h01);
    @(posedge clk_i) rs <= 4'h1;
    @(posedge clk_i) rs <= 4'h0;
    diff(1'b0);
    wait_lock(n);
    step(2'h1, 1'b1);
    repeat (2) @(posedge clk_i);
    check("step unlock", {7'h00, lock}, 8'h00);
    diff(1'b1);
    step(2'h1, 1'b0);
    diff(1'b0);
    step(2'h2, 1'b1);
    diff(1'b0);
    acc(1'b1, ADDR_PHASE, 8'h1b, 8'h00);
    check("source", {7'h00, src}, 8'h01);
    diff(1'b1);
    step(2'h1, 1'b0);
    diff(1'b1);
    @(posedge clk_i) rsel <= 1'b1;
    repeat (2) @(posedge clk_i);
    acc(1'b0, ADDR_STATUS, 8'h00, 8'h07);
    acc(1'b1, ADDR_PHASE, 8'h13, 8'h00);
    acc(1'b0, ADDR_PHASE, 8'h00, 8'h03);
    diff(1'b0);
    acc(1'b1, ADDR_PHASE, 8'h00, 8'h00);
    check("ports mode", {7'h00, src}, 8'h00);
    $display("test phase done");
  endtask : t_phase

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    $display("mismatch watchdog expected done seen hang");
    summarize();
  end

  initial begin
    repeat (20) @(posedge clk_i);
    check("reset outs", {2'h0, oclk, lock, src}, 8'h00);
    reset_i <= 1'b0;
    t_regs();
    t_lock();
    t_out();
    t_phase();
    summarize();
  end
endmodule : pdc_loop_ctrl_tb
